// File: ahr_top.sv
// ATA host register access: host registers and forwarded drive registers
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "ahr_defs.svh"

module ahr_top
	import ahr_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic [5:0]  addr,
	input  wire logic [15:0] wr_data,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	output logic [15:0]      rd_data,
	input  wire logic        xfer_active,
	output logic             dma_mode,
	output logic [2:0]       pio_mode,
	output logic [2:0]       ultra_dma_mode,
	input  wire logic [15:0] dd_in,
	output logic [15:0]      dd_out,
	output logic             dd_oe_n,
	output logic [2:0]       da,
	output logic             cs0_n,
	output logic             cs1_n,
	output logic             dior_n,
	output logic             diow_n
);

	// Host configuration and mode-timing storage
	logic [7:0]  cfg_q;                          // Mode selects
	logic [7:0]  pio_t_q  [`AHR_NUM_PIO_T];      // PIO timing 1..4
	logic [7:0]  mdma_t_q [`AHR_NUM_MDMA_T];     // Multiword DMA timing 1..4
	logic [7:0]  ultra_dma_mode_t_q [`AHR_NUM_ULTRA_DMA_MODE_T];     // Ultra DMA timing 1..9
	logic        dma_mode_q;                     // Local DMA-mode setting
	logic        busy_q;                         // Device access busy flag
	logic        fetched_q;                      // A fetched drive value is waiting
	logic        cyc_wr_q;                       // Direction of the cycle in flight
	logic [5:0]  fetch_addr_q;                   // Location the value belongs to
	logic [15:0] rd_data_q;                      // Read answer, one cycle after strobe
	logic [15:0] rd_data_d;                      // Next read answer

	// Decode of the address port
	logic        hit_cfg;
	logic        hit_stat;
	logic        hit_pio;
	logic        hit_mdma;
	logic        hit_ultra_dma_mode;
	logic        hit_task;
	logic        hit_ctl;
	logic        hit_drive;
	logic [5:0]  pio_idx;
	logic [5:0]  mdma_idx;
	logic [5:0]  ultra_dma_mode_idx;
	logic        drive_ok;
	logic        launch;
	logic        launch_rd;
	logic        consume;
	logic [2:0]  wr_pio;
	logic [2:0]  wr_ultra_dma_mode;
	logic [7:0]  status;

	// Cycle engine handshake
	logic        cyc_done;
	logic [15:0] cyc_rdata;

	// Clip a requested mode to the supported range 0..4
	function automatic logic [2:0] clip_mode(input logic [2:0] m);
		return (m > `AHR_MAX_MODE) ? `AHR_MAX_MODE : m;
	endfunction

	assign pio_idx   = addr - `AHR_OFF_PIO_T;
	assign mdma_idx  = addr - `AHR_OFF_MDMA_T;
	assign ultra_dma_mode_idx  = addr - `AHR_OFF_ULTRA_DMA_MODE_T;
	assign hit_cfg   = (addr == `AHR_OFF_CFG);
	assign hit_stat  = (addr == `AHR_OFF_STAT);
	assign hit_pio   = (addr >= `AHR_OFF_PIO_T) && (pio_idx < 6'(`AHR_NUM_PIO_T));
	assign hit_mdma  = (addr >= `AHR_OFF_MDMA_T) && (mdma_idx < 6'(`AHR_NUM_MDMA_T));
	assign hit_ultra_dma_mode  = (addr >= `AHR_OFF_ULTRA_DMA_MODE_T) && (ultra_dma_mode_idx < 6'(`AHR_NUM_ULTRA_DMA_MODE_T));
	// Task file: data .. command/status at eight consecutive locations
	assign hit_task  = ((addr & 6'h38) == `AHR_OFF_DRV_BASE);
	assign hit_ctl   = (addr == `AHR_OFF_DRV_CTL);
	assign hit_drive = hit_task | hit_ctl;

	// Drive access is held off while a data transfer runs or a cycle is busy
	assign drive_ok  = hit_drive && !xfer_active && !busy_q;
	assign consume   = rd_stb && hit_drive && fetched_q && (fetch_addr_q == addr);
	assign launch_rd = rd_stb && drive_ok && !consume;
	assign launch    = launch_rd || (wr_stb && drive_ok);
	assign wr_pio    = clip_mode(wr_data[`AHR_CFG_PIO_LSB +: 3]);
	assign wr_ultra_dma_mode   = clip_mode(wr_data[`AHR_CFG_ULTRA_DMA_MODE_LSB +: 3]);

	// Status word; transfer flag follows the data path directly
	assign status = {5'h00, dma_mode_q, busy_q, xfer_active};

	assign pio_mode       = cfg_q[`AHR_CFG_PIO_LSB +: 3];
	assign ultra_dma_mode = cfg_q[`AHR_CFG_ULTRA_DMA_MODE_LSB +: 3];
	assign dma_mode       = dma_mode_q;
	assign rd_data        = rd_data_q;

	// Read mux; unmapped locations answer zero
	always_comb begin
		rd_data_d = 16'h0000;
		if (hit_cfg) begin
			rd_data_d = {8'h00, cfg_q};
		end else if (hit_stat) begin
			rd_data_d = {8'h00, status};
		end else if (hit_pio) begin
			rd_data_d = {8'h00, pio_t_q[pio_idx[1:0]]};
		end else if (hit_mdma) begin
			rd_data_d = {8'h00, mdma_t_q[mdma_idx[1:0]]};
		end else if (hit_ultra_dma_mode) begin
			rd_data_d = {8'h00, ultra_dma_mode_t_q[ultra_dma_mode_idx[3:0]]};
		end else if (hit_drive) begin
			// Dummy read shows the stale latch; the follow-up read shows the fetch
			rd_data_d = cyc_rdata;
		end
	end

	// Read answer register: data stand only in the cycle after the strobe
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rd_data_q <= 16'h0000;
		end else begin
			rd_data_q <= rd_stb ? rd_data_d : 16'h0000;
		end
	end

	// Host configuration and timing writes
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cfg_q <= `AHR_CFG_RST;
			for (int i = 0; i < `AHR_NUM_PIO_T; i++) begin
				pio_t_q[i] <= `AHR_TIM_RST;
			end
			for (int i = 0; i < `AHR_NUM_MDMA_T; i++) begin
				mdma_t_q[i] <= `AHR_TIM_RST;
			end
			for (int i = 0; i < `AHR_NUM_ULTRA_DMA_MODE_T; i++) begin
				ultra_dma_mode_t_q[i] <= `AHR_TIM_RST;
			end
		end else if (wr_stb) begin
			if (hit_cfg) begin
				cfg_q <= {1'b0, wr_ultra_dma_mode, 1'b0, wr_pio};
			end
			if (hit_pio) begin
				pio_t_q[pio_idx[1:0]] <= wr_data[7:0];
			end
			if (hit_mdma) begin
				mdma_t_q[mdma_idx[1:0]] <= wr_data[7:0];
			end
			if (hit_ultra_dma_mode) begin
				ultra_dma_mode_t_q[ultra_dma_mode_idx[3:0]] <= wr_data[7:0];
			end
		end
	end

	// Local DMA-mode bit rides on command writes and never reaches the cable
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			dma_mode_q <= 1'b0;
		end else if (wr_stb && drive_ok && addr == `AHR_OFF_DRV_CMD) begin
			dma_mode_q <= wr_data[`AHR_DMA_MODE_BIT];
		end
	end

	// Busy flag: set at launch, cleared when the cable cycle reports done
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			busy_q <= 1'b0;
		end else if (launch) begin
			busy_q <= 1'b1;
		end else if (cyc_done) begin
			busy_q <= 1'b0;
		end
	end

	// Fetch bookkeeping: a completed read waits for its follow-up read
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			fetched_q    <= 1'b0;
			fetch_addr_q <= 6'h00;
		end else if (launch) begin
			fetched_q    <= 1'b0;
			fetch_addr_q <= addr;
		end else if (cyc_done && !cyc_wr_q) begin
			fetched_q <= 1'b1;
		end else if (consume) begin
			fetched_q <= 1'b0;
		end
	end

	// Direction of the cycle in flight, kept so the fetch flag only follows reads
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cyc_wr_q <= 1'b0;
		end else if (launch) begin
			cyc_wr_q <= wr_stb;
		end
	end

	// Cable engine; only the command byte is sent on a command write
	ahr_cycle u_cycle (
		.mclk      (mclk),
		.reset     (reset),
		.start     (launch),
		.is_write  (wr_stb),
		.sel_ctl   (hit_ctl),
		.reg_addr  (addr[2:0]),
		.wdata     ((addr == `AHR_OFF_DRV_CMD) ? {8'h00, wr_data[7:0]} : wr_data),
		.t_setup   (pio_t_q[0]),
		.t_active  (pio_t_q[1]),
		.t_recover (pio_t_q[2]),
		.dd_in     (dd_in),
		.busy      (),
		.done      (cyc_done),
		.rdata     (cyc_rdata),
		.da        (da),
		.cs0_n     (cs0_n),
		.cs1_n     (cs1_n),
		.dior_n    (dior_n),
		.diow_n    (diow_n),
		.dd_out    (dd_out),
		.dd_oe_n   (dd_oe_n)
	);

endmodule

`default_nettype wire

// File: ahr_defs.svh
// Constants for the ATA host register access block
`ifndef AHR_DEFS_SVH
`define AHR_DEFS_SVH

// Register offsets (word index on the 6-bit address port)
`define AHR_OFF_CFG        6'h00
`define AHR_OFF_STAT       6'h01
`define AHR_OFF_PIO_T      6'h04
`define AHR_OFF_MDMA_T     6'h08
`define AHR_OFF_ULTRA_DMA_MODE_T     6'h0C
`define AHR_OFF_DRV_BASE   6'h20
`define AHR_OFF_DRV_CMD    6'h27
`define AHR_OFF_DRV_CTL    6'h2E

// Counts of timing registers per mode
`define AHR_NUM_PIO_T      4
`define AHR_NUM_MDMA_T     4
`define AHR_NUM_ULTRA_DMA_MODE_T     9

// Configuration field positions
`define AHR_CFG_PIO_LSB    0
`define AHR_CFG_ULTRA_DMA_MODE_LSB   4
`define AHR_MAX_MODE       3'h4

// Status field positions
`define AHR_ST_XFER        0
`define AHR_ST_BUSY        1
`define AHR_ST_DMA         2

// Bit of the command write that carries the local DMA-mode setting
`define AHR_DMA_MODE_BIT   8

// Reset values
`define AHR_CFG_RST        8'h00
`define AHR_TIM_RST        8'h0F

// Timing reference and system clock rates in MHz
`define AHR_REF_MHZ        60
`define AHR_CLK_MHZ        50

`endif

// File: ahr_pkg.sv
// Types and shared arithmetic for the ATA host register access block
`include "ahr_defs.svh"

package ahr_pkg;

	// Phases of one drive register cycle on the cable
	typedef enum logic [1:0] {
		AHR_IDLE,
		AHR_SETUP,
		AHR_ACTIVE,
		AHR_RECOVER
	} ahr_phase_t;

	// Reference-clock ticks to mclk cycles, rounded up, at least one
	function automatic logic [8:0] ahr_ticks(input logic [7:0] ticks);
		logic [17:0] num;
		logic [17:0] res;
		num = 18'({10'h000, ticks}) * 18'(`AHR_CLK_MHZ) + 18'(`AHR_REF_MHZ - 1);
		res = num / 18'(`AHR_REF_MHZ);
		if (res == 18'h00000) begin
			res = 18'h00001;
		end
		return res[8:0];
	endfunction

endpackage

// File: ahr_cycle.sv
// One PIO register cycle on the drive cable: setup, strobe, recovery
`timescale 1ns/1ns
`default_nettype none
`include "ahr_defs.svh"

module ahr_cycle
	import ahr_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        start,
	input  wire logic        is_write,
	input  wire logic        sel_ctl,
	input  wire logic [2:0]  reg_addr,
	input  wire logic [15:0] wdata,
	input  wire logic [7:0]  t_setup,
	input  wire logic [7:0]  t_active,
	input  wire logic [7:0]  t_recover,
	input  wire logic [15:0] dd_in,
	output logic             busy,
	output logic             done,
	output logic [15:0]      rdata,
	output logic [2:0]       da,
	output logic             cs0_n,
	output logic             cs1_n,
	output logic             dior_n,
	output logic             diow_n,
	output logic [15:0]      dd_out,
	output logic             dd_oe_n
);

	ahr_phase_t  phase_q;     // Current phase
	logic [8:0]  cnt_q;       // Cycles left in the phase
	logic        wr_q;        // Cycle direction
	logic        last;        // Final cycle of the phase

	assign last = (cnt_q == 9'h001);
	assign busy = (phase_q != AHR_IDLE);

	// Phase sequencer; counts use the 60 MHz unit converted to mclk cycles
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			phase_q <= AHR_IDLE;
			cnt_q   <= 9'h000;
			wr_q    <= 1'b0;
			done    <= 1'b0;
			rdata   <= 16'h0000;
			da      <= 3'h0;
			cs0_n   <= 1'b1;
			cs1_n   <= 1'b1;
			dior_n  <= 1'b1;
			diow_n  <= 1'b1;
			dd_out  <= 16'h0000;
			dd_oe_n <= 1'b1;
		end else begin
			done <= 1'b0;
			case (phase_q)
				AHR_IDLE: begin
					if (start) begin
						// Address and chip selects lead the strobe by the setup time
						phase_q <= AHR_SETUP;
						cnt_q   <= ahr_ticks(t_setup);
						wr_q    <= is_write;
						da      <= reg_addr;
						cs0_n   <= sel_ctl;
						cs1_n   <= ~sel_ctl;
						dd_out  <= wdata;
						dd_oe_n <= ~is_write;
					end
				end
				AHR_SETUP: begin
					cnt_q <= cnt_q - 9'h001;
					if (last) begin
						phase_q <= AHR_ACTIVE;
						cnt_q   <= ahr_ticks(t_active);
						dior_n  <= wr_q;
						diow_n  <= ~wr_q;
					end
				end
				AHR_ACTIVE: begin
					cnt_q <= cnt_q - 9'h001;
					if (last) begin
						// Read data are caught on the strobe's last cycle
						if (!wr_q) begin
							rdata <= dd_in;
						end
						phase_q <= AHR_RECOVER;
						cnt_q   <= ahr_ticks(t_recover);
						dior_n  <= 1'b1;
						diow_n  <= 1'b1;
					end
				end
				AHR_RECOVER: begin
					cnt_q <= cnt_q - 9'h001;
					if (last) begin
						// Busy only drops once recovery is over and data are latched
						phase_q <= AHR_IDLE;
						done    <= 1'b1;
						cs0_n   <= 1'b1;
						cs1_n   <= 1'b1;
						dd_oe_n <= 1'b1;
					end
				end
				default: begin
					phase_q <= AHR_IDLE;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// File: ahr_top_properties.sv
// Checker of register port and cable behaviour of ahr_top
`timescale 1ns/1ns
`default_nettype none

module ahr_top_properties (
	input wire logic        mclk,
	input wire logic        reset,
	input wire logic [5:0]  addr,
	input wire logic [15:0] wr_data,
	input wire logic        wr_stb,
	input wire logic        rd_stb,
	input wire logic [15:0] rd_data,
	input wire logic        xfer_active,
	input wire logic        dma_mode,
	input wire logic [2:0]  pio_mode,
	input wire logic [2:0]  ultra_dma_mode,
	input wire logic [15:0] dd_in,
	input wire logic [15:0] dd_out,
	input wire logic        dd_oe_n,
	input wire logic [2:0]  da,
	input wire logic        cs0_n,
	input wire logic        cs1_n,
	input wire logic        dior_n,
	input wire logic        diow_n
);
	// Mode field of the write data after clipping to mode 4
	logic [2:0] pio_clip;
	logic       idle;
	assign pio_clip = (wr_data[2:0] > 3'h4) ? 3'h4 : wr_data[2:0];
	// Cable idle: neither select is active
	assign idle = cs0_n && cs1_n;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	property p_rd_zero;
		!$past(rd_stb) |-> rd_data == 16'h0000;
	endproperty
	a_rd_zero: assert property (p_rd_zero)
		else $error("read data not zero outside answer cycle");
	property p_mode_max;
		pio_mode <= 3'h4 && ultra_dma_mode <= 3'h4;
	endproperty
	a_mode_max: assert property (p_mode_max)
		else $error("mode above four");
	property p_cfg_wr;
		wr_stb && addr == 6'h00 |=> pio_mode == $past(pio_clip);
	endproperty
	a_cfg_wr: assert property (p_cfg_wr)
		else $error("pio mode not taken from write");
	property p_dma_local;
		$changed(dma_mode) |-> $past(wr_stb) && $past(addr) == 6'h27;
	endproperty
	a_dma_local: assert property (p_dma_local)
		else $error("dma mode changed without command write");
	property p_wr_drive;
		!diow_n |-> !dd_oe_n && !idle;
	endproperty
	a_wr_drive: assert property (p_wr_drive)
		else $error("write strobe without select or data drive");
	property p_rd_release;
		!dior_n |-> dd_oe_n && !idle;
	endproperty
	a_rd_release: assert property (p_rd_release)
		else $error("read strobe while driving data");
	property p_launch;
		idle[*3] ##0 (wr_stb && addr == 6'h21 && !xfer_active)
			|=> !cs0_n && da == 3'h1 && !dd_oe_n && diow_n;
	endproperty
	a_launch: assert property (p_launch)
		else $error("drive write not launched");
	property p_setup;
		$fell(cs0_n) |-> (dior_n && diow_n)[*8];
	endproperty
	a_setup: assert property (p_setup)
		else $error("strobe before setup time");
	property p_strobe_w;
		$fell(diow_n) |-> (!diow_n)[*8];
	endproperty
	a_strobe_w: assert property (p_strobe_w)
		else $error("write strobe too short");
	property p_tip_hold;
		xfer_active && idle && (wr_stb || rd_stb) && addr[5] |=> idle;
	endproperty
	a_tip_hold: assert property (p_tip_hold)
		else $error("drive access during transfer");
endmodule

`default_nettype wire

// File: ahr_drive_model.sv
// Behavioural task-file drive on the far side of the cable
`timescale 1ns/1ns
`default_nettype none

module ahr_drive_model (
	input  wire logic [2:0]  da,
	input  wire logic        cs0_n,
	input  wire logic        cs1_n,
	input  wire logic        dior_n,
	input  wire logic        diow_n,
	input  wire logic [15:0] dd_out,
	output logic [15:0]      dd_in
);
	logic [15:0] tf_q [0:7]; // Task-file store, 7 holds the command
	logic [7:0]  ctl_q;      // Control register
	logic [15:0] last_q;     // Last value put on the bus
	logic [15:0] val;        // Value of the selected register

	initial begin
		for (int i = 0; i < 8; i++) tf_q[i] = 16'h0000;
		ctl_q = 8'h00;
		last_q = 16'h0000;
	end
	// Status and alternate status both show the last command byte
	assign val = (!cs1_n || da == 3'h7) ? {8'h00, tf_q[7][7:0]} : tf_q[da];
	// Released bus shows the inverse so stale data cannot pass
	assign dd_in = (!dior_n && !(cs0_n && cs1_n)) ? val : ~last_q;

	// Writes land on the rising edge of the write strobe
	always @(posedge diow_n) begin
		if (!cs0_n) begin
			tf_q[da] <= dd_out;
		end else if (!cs1_n) begin
			ctl_q <= dd_out[7:0];
		end
	end
	always @(posedge dior_n) begin
		last_q <= val;
	end
endmodule

`default_nettype wire

// File: tb_top.sv
// Self-checking bench of ahr_top with a drive model
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	logic mclk, reset, wr_stb, rd_stb, xfer_active;
	logic [5:0]  addr;
	logic [15:0] wr_data, rd_data, dd_in, dd_out;
	logic        dma_mode, dd_oe_n, cs0_n, cs1_n, dior_n, diow_n;
	logic [2:0]  pio_mode, ultra_dma_mode, da;
	int          err_count = 0;
	int          n_compared = 0;
	logic [15:0] v;

	ahr_top i_ahr_top (.mclk, .reset, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data,
		.xfer_active, .dma_mode, .pio_mode, .ultra_dma_mode, .dd_in, .dd_out,
		.dd_oe_n, .da, .cs0_n, .cs1_n, .dior_n, .diow_n);
	ahr_drive_model i_ahr_drive_model (.da, .cs0_n, .cs1_n, .dior_n, .diow_n,
		.dd_out, .dd_in);

	// Free running 50 MHz clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// Compare two 16-bit values and count the outcome
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [5:0] a, output logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		// Taken at the edge that closes the answer cycle
		@(posedge mclk);
		d = rd_data;
	endtask
	// Poll one status bit until it reads zero, bounded
	task automatic poll(input int b);
		logic [15:0] s;
		s = 16'hFFFF;
		for (int i = 0; i < 200 && s[b] !== 1'b0; i++) rd(6'h01, s);
		chk({15'h0000, s[b]}, 16'h0000);
	endtask
	// Drive write: wait transfer flag, write, wait busy
	task automatic dwr(input logic [5:0] a, input logic [15:0] d);
		logic [15:0] s;
		poll(0);
		wr(a, d);
		rd(6'h01, s);
		chk({15'h0000, s[1]}, 16'h0001);
		poll(1);
	endtask
	// Drive read: dummy read fetches, second read returns it
	task automatic drd(input logic [5:0] a, output logic [15:0] d);
		poll(0);
		rd(a, d);
		poll(1);
		rd(a, d);
	endtask

	// Reset values, timing registers and an unmapped hole
	task automatic s_regs;
		rd(6'h00, v);
		chk(v, 16'h0000);
		for (int i = 4; i < 7; i++) begin
			rd(6'(i), v);
			chk(v, 16'h000F);
		end
		wr(6'h07, 16'h0033);
		wr(6'h0B, 16'h0044);
		wr(6'h14, 16'h0055);
		rd(6'h07, v);
		chk(v, 16'h0033);
		rd(6'h0B, v);
		chk(v, 16'h0044);
		rd(6'h14, v);
		chk(v, 16'h0055);
		rd(6'h3F, v);
		chk(v, 16'h0000);
	endtask
	// Mode fields above four are clipped
	task automatic s_cfg;
		wr(6'h00, 16'h0077);
		rd(6'h00, v);
		chk(v, 16'h0044);
		chk({13'h0000, ultra_dma_mode}, 16'h0004);
		chk({13'h0000, pio_mode}, 16'h0004);
		wr(6'h00, 16'h0032);
		rd(6'h00, v);
		chk(v, 16'h0032);
		chk({13'h0000, pio_mode}, 16'h0002);
		chk({13'h0000, ultra_dma_mode}, 16'h0003);
	endtask
	// Task-file write and read through the cable
	task automatic s_tf;
		dwr(6'h20, 16'hBEEF);
		chk(i_ahr_drive_model.tf_q[0], 16'hBEEF);
		dwr(6'h22, 16'h005A);
		drd(6'h20, v);
		chk(v, 16'hBEEF);
		drd(6'h22, v);
		chk(v, 16'h005A);
	endtask
	// Command with local mode bit, control and alternate status
	task automatic s_cmd;
		dwr(6'h27, 16'h01EC);
		chk(i_ahr_drive_model.tf_q[7], 16'h00EC);
		chk({15'h0000, dma_mode}, 16'h0001);
		rd(6'h01, v);
		chk({15'h0000, v[2]}, 16'h0001);
		drd(6'h27, v);
		chk(v, 16'h00EC);
		dwr(6'h2E, 16'h0002);
		chk({8'h00, i_ahr_drive_model.ctl_q}, 16'h0002);
		drd(6'h2E, v);
		chk(v, 16'h00EC);
	endtask
	// Drive access is refused while a transfer runs
	task automatic s_tip;
		@(posedge mclk);
		xfer_active <= 1'b1;
		rd(6'h01, v);
		chk({15'h0000, v[0]}, 16'h0001);
		wr(6'h21, 16'h0077);
		repeat (60) @(posedge mclk);
		chk(i_ahr_drive_model.tf_q[1], 16'h0000);
		xfer_active <= 1'b0;
		dwr(6'h21, 16'h0011);
		drd(6'h21, v);
		chk(v, 16'h0011);
	endtask
	// Reset in mid-run brings modes and timing back to their defaults
	task automatic s_rst;
		@(posedge mclk);
		reset <= 1'b1;
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		chk({15'h0000, dma_mode}, 16'h0000);
		rd(6'h07, v);
		chk(v, 16'h000F);
		rd(6'h00, v);
		chk(v, 16'h0000);
	endtask

	// Counts, verdict and end of run
	task automatic close_out;
		$display("compared=%0d errors=%0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Main sequence after ten reset cycles
	initial begin
		{reset, wr_stb, rd_stb, xfer_active, addr, wr_data} = {1'b1, 25'h0};
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		s_regs;
		s_cfg;
		s_tf;
		s_cmd;
		s_tip;
		s_rst;
		close_out;
	end
	// Watchdog well beyond the expected run of under a thousand cycles
	initial begin
		#400000;
		err_count++;
		close_out;
	end
endmodule

bind ahr_top ahr_top_properties i_ahr_top_properties (.mclk, .reset, .addr, .wr_data,
	.wr_stb, .rd_stb, .rd_data, .xfer_active, .dma_mode, .pio_mode, .ultra_dma_mode,
	.dd_in, .dd_out, .dd_oe_n, .da, .cs0_n, .cs1_n, .dior_n, .diow_n);

`default_nettype wire
